// [core/xfr_addr_unit.v]
// Effective address former for the operand addressing modes.
`timescale 1ns/100ps
`default_nettype none
`include "xfr_defs.vh"

module xfr_addr_unit (
   // Mode and operand bytes, first byte latched, second byte live
   input wire [3:0] mode,
   input wire [7:0] first_byte,
   input wire [7:0] last_byte,
   // Pointer registers
   input wire [15:0] index_pair,
   input wire [15:0] stack_ptr,
   // Results
   output reg [15:0] eff_addr,
   output reg [1:0] operand_bytes,
   output reg post_inc
);

   wire [15:0] off8 = {8'h00, last_byte};
   wire [15:0] off16 = {first_byte, last_byte};

   always @* begin
      eff_addr = off8;
      operand_bytes = 2'h1;
      post_inc = 1'b0;
      case (mode)
         `AM_DIR: begin
            eff_addr = off8;
         end
         `AM_EXT: begin
            eff_addr = off16;
            operand_bytes = 2'h2;
         end
         `AM_IX: begin
            eff_addr = index_pair;
            operand_bytes = 2'h0;
         end
         `AM_IX1: begin
            eff_addr = index_pair + off8;
         end
         `AM_IX2: begin
            eff_addr = index_pair + off16;
            operand_bytes = 2'h2;
         end
         `AM_IXP: begin
            eff_addr = index_pair;
            operand_bytes = 2'h0;
            post_inc = 1'b1;
         end
         `AM_IX1P: begin
            eff_addr = index_pair + off8;
            post_inc = 1'b1;
         end
         `AM_SP1: begin
            eff_addr = stack_ptr + off8;
         end
         `AM_SP2: begin
            eff_addr = stack_ptr + off16;
            operand_bytes = 2'h2;
         end
         `AM_DIR_REL: begin
            // Direct address first, branch offset second.
            eff_addr = {8'h00, first_byte};
            operand_bytes = 2'h2;
         end
         `AM_IMD: begin
            // Immediate byte first, direct destination second.
            eff_addr = off8;
            operand_bytes = 2'h2;
         end
         `AM_DD: begin
            eff_addr = {8'h00, first_byte};
            operand_bytes = 2'h2;
         end
         `AM_DIXP: begin
            eff_addr = off8;
            post_inc = 1'b1;
         end
         `AM_IXPD: begin
            eff_addr = index_pair;
            post_inc = 1'b1;
         end
         default: begin
            eff_addr = off8;
         end
      endcase
   end

endmodule
`default_nettype wire

// [core/xfr_core.v]
// Sequencer for transfer, test and software interrupt instructions.
`timescale 1ns/100ps
`default_nettype none
`include "xfr_defs.vh"

module xfr_core #(
   parameter [15:0] RESET_PC = 16'h0000,
   parameter [15:0] VECTOR_HI_ADDR = 16'hFFFC,
   parameter [15:0] VECTOR_LO_ADDR = 16'hFFFD
) (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Memory bus, read data valid in the cycle the read is presented
   output reg [15:0] mem_addr,
   output reg mem_rd,
   output reg mem_wr,
   output reg [7:0] mem_wdata,
   input wire [7:0] mem_rdata,
   // Programmer visible state
   output reg [7:0] acc,
   output reg [15:0] index_pair,
   output reg [15:0] stack_ptr,
   output reg [7:0] condition_flags_reg,
   output reg [15:0] prog_counter,
   // Status pulses
   output reg insn_start,
   output reg unsupported_op
);

   // -------------------------------------------------------------------
   // Sequencer state
   // -------------------------------------------------------------------
   reg [3:0] cnt;
   reg [7:0] op;
   reg prefixed;
   reg [7:0] first_byte;
   reg [7:0] vec_hi;

   reg [3:0] next_cnt;
   reg [7:0] next_op;
   reg next_prefixed;
   reg [7:0] next_first_byte;
   reg [7:0] next_vec_hi;
   reg [15:0] next_mem_addr;
   reg next_mem_rd;
   reg next_mem_wr;
   reg [7:0] next_mem_wdata;
   reg [7:0] next_acc;
   reg [15:0] next_index_pair;
   reg [15:0] next_stack_ptr;
   reg [7:0] next_flags;
   reg [15:0] next_pc;
   reg next_unsupported;
   reg done;
   reg [15:0] advance;
   reg [3:0] amode;

   wire [7:0] cur_op = (cnt == 4'h0) ? mem_rdata : op;
   wire [15:0] ret_pc = prog_counter + `PC_ONE;
   wire [15:0] a_addr;
   wire a_postinc;

   // -------------------------------------------------------------------
   // Address former
   // -------------------------------------------------------------------
   xfr_addr_unit u_addr (
      .mode(amode),
      .first_byte(first_byte),
      .last_byte(mem_rdata),
      .index_pair(index_pair),
      .stack_ptr(stack_ptr),
      .eff_addr(a_addr),
      .operand_bytes(),
      .post_inc(a_postinc)
   );

   // -------------------------------------------------------------------
   // Test operation: subtract zero, no result kept
   // -------------------------------------------------------------------
   function [7:0] test_flags;
      input [7:0] flags;
      input [7:0] data;
      begin
         test_flags = flags;
         test_flags[`FLG_V] = 1'b0;
         test_flags[`FLG_N] = data[7];
         test_flags[`FLG_Z] = (data == 8'h00);
      end
   endfunction

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always @* begin
      next_cnt = cnt + 4'h1;
      next_op = op;
      next_prefixed = prefixed;
      next_first_byte = first_byte;
      next_vec_hi = vec_hi;
      next_mem_addr = mem_addr;
      next_mem_rd = 1'b0;
      next_mem_wr = 1'b0;
      next_mem_wdata = mem_wdata;
      next_acc = acc;
      next_index_pair = index_pair;
      next_stack_ptr = stack_ptr;
      next_flags = condition_flags_reg;
      next_pc = prog_counter;
      next_unsupported = 1'b0;
      done = 1'b0;
      advance = `PC_ONE;
      amode = `AM_DIR;
      if (cnt == 4'h0) begin
         next_op = mem_rdata;
         next_prefixed = (mem_rdata == `OP_STACK_PREFIX);
      end
      if (prefixed || (cnt == 4'h0 && mem_rdata == `OP_STACK_PREFIX)) begin
         amode = `AM_SP1;
         case (cnt)
            4'h0: begin
               next_mem_rd = 1'b1;
               next_mem_addr = prog_counter + `PC_ONE;
            end
            4'h1: begin
               next_op = mem_rdata;
               if (mem_rdata == `OP_TEST_IX1) begin
                  next_mem_rd = 1'b1;
                  next_mem_addr = prog_counter + `PC_TWO;
               end else begin
                  next_unsupported = 1'b1;
                  advance = `PC_TWO;
                  done = 1'b1;
               end
            end
            4'h2: begin
               next_mem_rd = 1'b1;
               next_mem_addr = a_addr;
            end
            default: begin
               // Stack offset test ends here.
               next_flags = test_flags(condition_flags_reg, mem_rdata);
               advance = {12'h000, `CYC_TEST_SP1} - `PC_ONE;
               done = (cnt == `CYC_TEST_SP1 - 4'h1);
            end
         endcase
      end else begin
         case (cur_op)
            `OP_SOFT_INT: begin
               case (cnt)
                  4'h0: begin
                     next_mem_addr = mem_addr;
                  end
                  4'h1: begin
                     next_mem_wr = 1'b1;
                     next_mem_addr = stack_ptr;
                     next_mem_wdata = ret_pc[7:0];
                  end
                  4'h2, 4'h3, 4'h4, 4'h5: begin
                     next_stack_ptr = stack_ptr - `PC_ONE;
                     next_mem_wr = 1'b1;
                     next_mem_addr = stack_ptr - `PC_ONE;
                     case (cnt)
                        4'h2: next_mem_wdata = ret_pc[15:8];
                        4'h3: next_mem_wdata = index_pair[7:0];
                        4'h4: next_mem_wdata = acc;
                        default: next_mem_wdata = condition_flags_reg;
                     endcase
                  end
                  4'h6: begin
                     next_stack_ptr = stack_ptr - `PC_ONE;
                     next_flags[`FLG_I] = 1'b1;
                     next_mem_rd = 1'b1;
                     next_mem_addr = VECTOR_HI_ADDR;
                  end
                  4'h7: begin
                     next_vec_hi = mem_rdata;
                     next_mem_rd = 1'b1;
                     next_mem_addr = VECTOR_LO_ADDR;
                  end
                  default: begin
                     done = (cnt == `CYC_SOFT_INT - 4'h1);
                  end
               endcase
            end
            `OP_ACC_TO_FLAGS: begin
               if (cnt == `CYC_ACC_TO_FLAGS - 4'h1) begin
                  next_flags = acc | `FLG_FIXED_ONES;
                  done = 1'b1;
               end
            end
            `OP_FLAGS_TO_ACC: begin
               next_acc = condition_flags_reg;
               done = 1'b1;
            end
            `OP_ACC_TO_INDEX: begin
               next_index_pair[7:0] = acc;
               done = 1'b1;
            end
            `OP_INDEX_TO_ACC: begin
               next_acc = index_pair[7:0];
               done = 1'b1;
            end
            `OP_STACK_TO_INDEX: begin
               if (cnt == `CYC_STACK_XFER - 4'h1) begin
                  next_index_pair = stack_ptr + `PC_ONE;
                  done = 1'b1;
               end
            end
            `OP_INDEX_TO_STACK: begin
               if (cnt == `CYC_STACK_XFER - 4'h1) begin
                  next_stack_ptr = index_pair - `PC_ONE;
                  done = 1'b1;
               end
            end
            `OP_TEST_ACC: begin
               next_flags = test_flags(condition_flags_reg, acc);
               done = 1'b1;
            end
            `OP_TEST_X: begin
               next_flags = test_flags(condition_flags_reg,
                                       index_pair[7:0]);
               done = 1'b1;
            end
            `OP_TEST_DIR, `OP_TEST_IX1: begin
               amode = (cur_op == `OP_TEST_DIR) ? `AM_DIR : `AM_IX1;
               case (cnt)
                  4'h0: begin
                     next_mem_rd = 1'b1;
                     next_mem_addr = prog_counter + `PC_ONE;
                  end
                  4'h1: begin
                     next_first_byte = mem_rdata;
                     next_mem_rd = 1'b1;
                     next_mem_addr = a_addr;
                  end
                  default: begin
                     next_flags = test_flags(condition_flags_reg, mem_rdata);
                     if (a_postinc) begin
                        next_index_pair = index_pair + `PC_ONE;
                     end
                     advance = `PC_TWO;
                     done = 1'b1;
                  end
               endcase
            end
            `OP_TEST_IX: begin
               amode = `AM_IX;
               if (cnt == 4'h0) begin
                  next_mem_rd = 1'b1;
                  next_mem_addr = a_addr;
               end else begin
                  next_flags = test_flags(condition_flags_reg, mem_rdata);
                  done = (cnt == `CYC_TEST_IX - 4'h1);
               end
            end
            default: begin
               next_unsupported = 1'b1;
               done = 1'b1;
            end
         endcase
      end
      if (done) begin
         next_cnt = 4'h0;
         next_prefixed = 1'b0;
         if (!prefixed && cur_op == `OP_SOFT_INT) begin
            next_pc = {vec_hi, mem_rdata};
         end else begin
            next_pc = prog_counter + advance;
         end
         next_mem_rd = 1'b1;
         next_mem_wr = 1'b0;
         next_mem_addr = next_pc;
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 4'h0;
         op <= 8'h00;
         prefixed <= 1'b0;
         first_byte <= 8'h00;
         vec_hi <= 8'h00;
         mem_addr <= RESET_PC;
         mem_rd <= 1'b1;
         mem_wr <= 1'b0;
         mem_wdata <= 8'h00;
         acc <= `ACC_RESET;
         index_pair <= `HX_RESET;
         stack_ptr <= `SP_RESET;
         condition_flags_reg <= `FLG_RESET;
         prog_counter <= RESET_PC;
         insn_start <= 1'b1;
         unsupported_op <= 1'b0;
      end else begin
         cnt <= next_cnt;
         op <= next_op;
         prefixed <= next_prefixed;
         first_byte <= next_first_byte;
         vec_hi <= next_vec_hi;
         mem_addr <= next_mem_addr;
         mem_rd <= next_mem_rd;
         mem_wr <= next_mem_wr;
         mem_wdata <= next_mem_wdata;
         acc <= next_acc;
         index_pair <= next_index_pair;
         stack_ptr <= next_stack_ptr;
         condition_flags_reg <= next_flags;
         prog_counter <= next_pc;
         insn_start <= done;
         unsupported_op <= next_unsupported;
      end
   end

endmodule
`default_nettype wire

// [core/xfr_defs.vh]
// Constants for the transfer, test and software interrupt sequencer.
// Functional notes
// - Software interrupt 83: 9 cycles, return address PC+1, push PC_LOW_BYTE,PC_HIGH_BYTE,X,A,flags.
// - After stacking, set interrupt mask and load PC from the vector.
// - Opcode 84, 2 cycles: flag register takes the accumulator bits, with bits 6 and 5 forced to one.
// - Opcode 85, 1 cycle: accumulator takes flag register, flags unchanged.
// - Opcodes 97 and 9F, 1 cycle each: copy A and X, flags unchanged.
// - Opcode 95, 2 cycles: index pair takes stack pointer plus one.
// - Opcode 94, 2 cycles: stack pointer takes index pair minus one.
// - Test clears overflow, sets negative and zero, keeps H, I and C.
// - Extended address comes from two bytes, high byte first.
// - 16-bit index offset is two bytes high first; 8-bit offset one byte.
// - Post-increment modes except direct-to-postinc address through the index pair, then increment it.
// - Direct branch forms carry a direct address byte then an offset byte.
// - Moves support immediate, direct, direct-to-postinc, postinc-to-direct forms.
// - Stack offset modes add 8 or 16-bit offset to SP; prefix 9E.
`ifndef XFR_DEFS_VH
`define XFR_DEFS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OP_SOFT_INT 8'h83
`define OP_ACC_TO_FLAGS 8'h84
`define OP_FLAGS_TO_ACC 8'h85
`define OP_ACC_TO_INDEX 8'h97
`define OP_INDEX_TO_ACC 8'h9F
`define OP_STACK_TO_INDEX 8'h95
`define OP_INDEX_TO_STACK 8'h94
`define OP_TEST_DIR 8'h3D
`define OP_TEST_ACC 8'h4D
`define OP_TEST_X 8'h5D
`define OP_TEST_IX1 8'h6D
`define OP_TEST_IX 8'h7D
`define OP_STACK_PREFIX 8'h9E

// ----------------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------------
`define CYC_SOFT_INT 4'h9
`define CYC_ACC_TO_FLAGS 4'h2
`define CYC_STACK_XFER 4'h2
`define CYC_TEST_DIR 4'h3
`define CYC_TEST_IX1 4'h3
`define CYC_TEST_IX 4'h2
`define CYC_TEST_SP1 4'h4

// ----------------------------------------------------------------------
// Flag register layout and reset values
// ----------------------------------------------------------------------
`define FLG_V 7
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0
`define FLG_FIXED_ONES 8'h60
`define FLG_RESET 8'h68
`define SP_RESET 16'h00FF
`define HX_RESET 16'h0000
`define ACC_RESET 8'h00
`define PC_ONE 16'h0001
`define PC_TWO 16'h0002

// ----------------------------------------------------------------------
// Addressing modes
// ----------------------------------------------------------------------
`define AM_DIR 4'h0
`define AM_EXT 4'h1
`define AM_IX 4'h2
`define AM_IX1 4'h3
`define AM_IX2 4'h4
`define AM_IXP 4'h5
`define AM_IX1P 4'h6
`define AM_SP1 4'h7
`define AM_SP2 4'h8
`define AM_DIR_REL 4'h9
`define AM_IMD 4'hA
`define AM_DD 4'hB
`define AM_DIXP 4'hC
`define AM_IXPD 4'hD

`endif

// [test/xfr_core_chk.sv]
// Concurrent checker for the transfer, test and software interrupt core.
`timescale 1ns/100ps
`default_nettype none
module xfr_core_chk #(
   parameter [15:0] VECTOR_HI_ADDR = 16'hFFFC,
   parameter [15:0] VECTOR_LO_ADDR = 16'hFFFD
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Memory bus
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // Visible state
   input wire logic [7:0] acc,
   input wire logic [15:0] index_pair,
   input wire logic [15:0] stack_ptr,
   input wire logic [7:0] condition_flags_reg,
   input wire logic [15:0] prog_counter,
   input wire logic insn_start
);
   // ---------------------------------------------------------------
   // Helper values
   // ---------------------------------------------------------------
   logic [7:0] ret_low;
   logic [7:0] idx_low;
   logic [15:0] copy_val;
   logic [7:0] acc_flags;
   logic [7:0] mem_flags;
   assign ret_low = prog_counter[7:0] + 8'h01;
   assign idx_low = index_pair[7:0];
   assign copy_val = {index_pair[15:8], acc};
   assign acc_flags = {1'b0, condition_flags_reg[6:3], acc[7],
      acc == 8'h00, condition_flags_reg[0]};
   assign mem_flags = {1'b0, condition_flags_reg[6:3], mem_rdata[7],
      mem_rdata == 8'h00, condition_flags_reg[0]};

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_flags_load: assert property (insn_start && mem_rdata == 8'h84 |=>
      !insn_start ##1 insn_start && condition_flags_reg == ($past(acc, 2) | 8'h60))
      else $error("flag load from accumulator wrong");
   a_flags_read: assert property (insn_start && mem_rdata == 8'h85 |=>
      insn_start && acc == $past(condition_flags_reg)
      && mem_addr == $past(prog_counter) + 16'h0001)
      else $error("accumulator load from flags wrong");
   a_acc_copy: assert property (insn_start && mem_rdata == 8'h97 |=>
      insn_start && index_pair == $past(copy_val) && $stable(condition_flags_reg))
      else $error("accumulator to index copy wrong");
   a_index_copy: assert property (insn_start && mem_rdata == 8'h9F |=>
      insn_start && acc == $past(idx_low) && $stable(condition_flags_reg))
      else $error("index to accumulator copy wrong");
   a_stack_index: assert property (insn_start && mem_rdata == 8'h95 |=>
      !mem_rd ##1 insn_start && index_pair == $past(stack_ptr, 2) + 16'h0001)
      else $error("stack to index transfer wrong");
   a_index_stack: assert property (insn_start && mem_rdata == 8'h94 |=>
      !insn_start ##1 insn_start && stack_ptr == $past(index_pair, 2) - 16'h0001)
      else $error("index to stack transfer wrong");
   a_test_acc: assert property (insn_start && mem_rdata == 8'h4D |=>
      insn_start && condition_flags_reg == $past(acc_flags) && $stable(acc))
      else $error("accumulator test flags wrong");
   a_test_direct: assert property (insn_start && mem_rdata == 8'h3D |=>
      mem_rd ##1 mem_rd && mem_addr == {8'h00, $past(mem_rdata)}
      ##1 insn_start && condition_flags_reg == $past(mem_flags))
      else $error("direct test sequence wrong");
   a_swi_stack: assert property (insn_start && mem_rdata == 8'h83 |=>
      !mem_wr ##1 mem_wr && mem_addr == $past(stack_ptr, 2)
      && mem_wdata == $past(ret_low, 2)
      ##1 mem_wr && mem_addr == $past(mem_addr) - 16'h0001)
      else $error("software interrupt stacking wrong");
   a_swi_vector: assert property (insn_start && mem_rdata == 8'h83 |=>
      ##6 mem_rd && mem_addr == VECTOR_HI_ADDR && condition_flags_reg[3]
      ##1 mem_rd && mem_addr == VECTOR_LO_ADDR
      ##1 insn_start && prog_counter == {$past(mem_rdata, 2), $past(mem_rdata)})
      else $error("software interrupt vector fetch wrong");
endmodule

bind xfr_core xfr_core_chk #(
   .VECTOR_HI_ADDR(VECTOR_HI_ADDR),
   .VECTOR_LO_ADDR(VECTOR_LO_ADDR)
) u_xfr_core_chk (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .mem_addr(mem_addr),
   .mem_rd(mem_rd),
   .mem_wr(mem_wr),
   .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata),
   .acc(acc),
   .index_pair(index_pair),
   .stack_ptr(stack_ptr),
   .condition_flags_reg(condition_flags_reg),
   .prog_counter(prog_counter),
   .insn_start(insn_start)
);
`default_nettype wire

// [test/xfr_core_tb.sv]
// Self-checking bench for the transfer, test and software interrupt core.
`timescale 1ns/100ps
`default_nettype none
module xfr_core_tb;
   logic sys_clk;
   logic sys_rst;
   logic [15:0] mem_addr;
   logic mem_rd;
   logic mem_wr;
   logic [7:0] mem_wdata;
   wire [7:0] mem_rdata;
   logic [7:0] acc;
   logic [15:0] index_pair;
   logic [15:0] stack_ptr;
   logic [7:0] condition_flags_reg;
   logic [15:0] prog_counter;
   logic insn_start;
   logic unsupported_op;
   logic [7:0] mem [0:65535];
   logic [7:0] prog [0:17] = '{8'h84, 8'h95, 8'h3D, 8'h20, 8'h85, 8'h97,
      8'h94, 8'h4D, 8'h6D, 8'h10, 8'h7D, 8'h9E, 8'h6D, 8'h05, 8'h5D, 8'h85,
      8'h9F, 8'h83};
   int errors;
   int samples_checked;
   int cycles;

   xfr_core u_xfr_core (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .mem_addr(mem_addr),
      .mem_rd(mem_rd),
      .mem_wr(mem_wr),
      .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata),
      .acc(acc),
      .index_pair(index_pair),
      .stack_ptr(stack_ptr),
      .condition_flags_reg(condition_flags_reg),
      .prog_counter(prog_counter),
      .insn_start(insn_start),
      .unsupported_op(unsupported_op)
   );

   // ---------------------------------------------------------------
   // Zero wait state memory
   // ---------------------------------------------------------------
   assign mem_rdata = mem[mem_addr];
   always @(posedge sys_clk) begin
      if (mem_wr === 1'b1)
         mem[mem_addr] <= mem_wdata;
   end

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         test_done();
      end
   end

   // ---------------------------------------------------------------
   // Common tasks
   // ---------------------------------------------------------------
   task automatic test_done;
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] exp, input logic [7:0] act);
      samples_checked++;
      if (act !== exp) begin
         errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask

   task automatic chk16(input logic [15:0] exp, input logic [15:0] act);
      samples_checked++;
      if (act !== exp) begin
         errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask

   // Checks the opcode address, then counts cycles to the next start.
   task automatic run_insn(input logic [15:0] at, input int len);
      int n;
      n = 0;
      chk16(at, prog_counter);
      chk8(8'h01, {7'h00, insn_start});
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (insn_start !== 1'b1 && n < 20);
      chk8(len[7:0], n[7:0]);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_flag_and_stack;
      run_insn(16'h0000, 2);
      chk8(8'h60, condition_flags_reg);
      run_insn(16'h0001, 2);
      chk16(16'h0100, index_pair);
      chk8(8'h60, condition_flags_reg);
   endtask

   task automatic t_copies;
      run_insn(16'h0002, 3);
      chk8(8'h64, condition_flags_reg);
      run_insn(16'h0004, 1);
      chk8(8'h64, acc);
      run_insn(16'h0005, 1);
      chk16(16'h0164, index_pair);
      run_insn(16'h0006, 2);
      chk16(16'h0163, stack_ptr);
      chk8(8'h64, condition_flags_reg);
   endtask

   task automatic t_test_modes;
      run_insn(16'h0007, 1);
      chk8(8'h60, condition_flags_reg);
      chk8(8'h64, acc);
      run_insn(16'h0008, 3);
      chk8(8'h62, condition_flags_reg);
      run_insn(16'h000A, 2);
      chk8(8'h64, condition_flags_reg);
      run_insn(16'h000B, 4);
      chk8(8'h62, condition_flags_reg);
      run_insn(16'h000E, 1);
      chk8(8'h60, condition_flags_reg);
      run_insn(16'h000F, 1);
      run_insn(16'h0010, 1);
      chk8(8'h64, acc);
   endtask

   task automatic t_soft_int;
      run_insn(16'h0011, 9);
      chk16(16'h0100, prog_counter);
      chk16(16'h015E, stack_ptr);
      chk8(8'h68, condition_flags_reg);
      chk8(8'h12, mem[16'h0163]);
      chk8(8'h00, mem[16'h0162]);
      chk8(8'h64, mem[16'h0161]);
      chk8(8'h64, mem[16'h0160]);
      chk8(8'h60, mem[16'h015F]);
   endtask

   task automatic t_unknown;
      run_insn(16'h0100, 1);
      chk8(8'h01, {7'h00, unsupported_op});
      run_insn(16'h0101, 1);
   endtask

   initial begin
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      sys_rst = 1'b1;
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h00;
      for (int i = 0; i < 18; i++)
         mem[i] = prog[i];
      mem[16'h0020] = 8'h80;
      mem[16'h0164] = 8'hFF;
      mem[16'h0101] = 8'h4D;
      mem[16'hFFFC] = 8'h01;
      mem[16'hFFFD] = 8'h00;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      t_flag_and_stack();
      t_copies();
      t_test_modes();
      t_soft_int();
      t_unknown();
      test_done();
   end
endmodule
`default_nettype wire
